// file: hw/spi_eeprom_cfg.svh
`ifndef SPI_EEPROM_CFG_SVH
`define SPI_EEPROM_CFG_SVH

// Opcodes
`define OP_SET_WRITE_LATCH 8'h06
`define OP_CLEAR_WRITE_LATCH 8'h04
`define OP_STATUS_READ 8'h05
`define OP_STATUS_WRITE 8'h01
`define OP_ARRAY_READ 8'h03
`define OP_ARRAY_WRITE 8'h02
`define OP_SECURE_READ 8'h83
`define OP_SECURE_WRITE 8'h82

// Status bit positions
`define ST_WIP_BIT 0
`define ST_WEL_BIT 1
`define ST_BP_LO_BIT 2
`define ST_BP_HI_BIT 3
`define ST_ECC_BIT 4
`define ST_LOCK_BIT 7
`define ST_RESET 8'h00

// Block-protect codes
`define BP_NONE 2'h0
`define BP_QUARTER 2'h1
`define BP_HALF 2'h2
`define BP_ALL 2'h3

// Security address selectors (A10:A9)
`define SEC_SEL_DATA 2'h0
`define SEC_SEL_LOCK 2'h2
`define LOCK_DATA_BIT 1

// Timing
`define SYS_CLK_PERIOD_NS 5
`define WRITE_TIME_NS 5000000
`define WRITE_CYCLES (`WRITE_TIME_NS / `SYS_CLK_PERIOD_NS)

`endif

// file: hw/spi_eeprom_pkg.sv
package spi_eeprom_pkg;

	typedef enum logic [2:0] {
		WK_NONE,
		WK_ARRAY,
		WK_STATUS,
		WK_SECTOR,
		WK_LOCK
	} write_kind_type;

	typedef enum logic [2:0] {
		RT_NONE,
		RT_ARRAY,
		RT_SECTOR,
		RT_LOCK_STATUS,
		RT_UID
	} read_target_type;

	typedef enum logic {
		ENG_IDLE,
		ENG_BUSY
	} engine_state_type;

endpackage : spi_eeprom_pkg

// file: hw/spi_eeprom_status_cmd.sv
`timescale 1ns/1ps
`include "spi_eeprom_cfg.svh"
module spi_eeprom_status_cmd #(
	parameter int WRITE_CYCLES = `WRITE_CYCLES,
	parameter int CNT_W = $clog2(WRITE_CYCLES + 1)
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic spi_clk_in,
	input wire logic cs_n_in,
	input wire logic serial_in,
	input wire logic wp_n_in,
	input wire logic ecc_read_done_in,
	input wire logic ecc_corrected_in,
	output logic so_out,
	output logic so_oe_out,
	output logic write_start_out,
	output spi_eeprom_pkg::write_kind_type write_kind_out,
	output logic [15:0] write_addr_out,
	output logic [7:0] write_data_out,
	output spi_eeprom_pkg::read_target_type read_target_out,
	output logic [5:0] read_index_out,
	output logic [7:0] device_status_out,
	output logic sector_locked_out
);

	////////////////////////////////////////////////////////////////////////////////
	// Link domain (serial clock)

	logic fresh_reg;
	logic [2:0] bit_low_reg;
	logic [2:0] byte_cnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] op_reg;
	logic [7:0] byte1_reg;
	logic [15:0] addr_reg;
	logic [7:0] byte3_reg;
	logic frame_tog_reg;
	logic [7:0] st_meta_reg;
	logic [7:0] st_link_reg;
	logic [7:0] in_byte;
	logic rd_active;
	logic so_reg;

	assign in_byte = {shift_reg[6:0], serial_in};

	// Cleared while deselected, so the first rising edge of a frame is known
	always_ff @(posedge spi_clk_in or posedge rst_in or posedge cs_n_in) begin
		if (rst_in || cs_n_in) begin
			fresh_reg <= 1'b0;
		end else begin
			fresh_reg <= 1'b1;
		end
	end

	// Counters not reset by select: they must survive until the system side reads them
	always_ff @(posedge spi_clk_in or posedge rst_in) begin
		if (rst_in) begin
			bit_low_reg <= 3'h0;
			byte_cnt_reg <= 3'h0;
			shift_reg <= 8'h00;
			frame_tog_reg <= 1'b0;
		end else if (!fresh_reg) begin
			bit_low_reg <= 3'h1;
			byte_cnt_reg <= 3'h0;
			shift_reg <= {7'h00, serial_in};
			frame_tog_reg <= ~frame_tog_reg;
		end else begin
			bit_low_reg <= bit_low_reg + 3'h1;
			shift_reg <= in_byte;
			if (bit_low_reg == 3'h7 && byte_cnt_reg != 3'h7) begin
				byte_cnt_reg <= byte_cnt_reg + 3'h1;
			end
		end
	end

	// Byte capture; a frame of one byte completes when the count is 7 on entry
	always_ff @(posedge spi_clk_in or posedge rst_in) begin
		if (rst_in) begin
			op_reg <= 8'h00;
			byte1_reg <= 8'h00;
			addr_reg <= 16'h0000;
			byte3_reg <= 8'h00;
		end else if (fresh_reg && bit_low_reg == 3'h7) begin
			case (byte_cnt_reg)
				3'h0: op_reg <= in_byte;
				3'h1: begin
					byte1_reg <= in_byte;
					addr_reg[15:8] <= in_byte;
				end
				3'h2: addr_reg[7:0] <= in_byte;
				3'h3: byte3_reg <= in_byte;
				default: ;
			endcase
		end
	end

	// Status bits are independent flags, each synchronised on its own
	always_ff @(posedge spi_clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_meta_reg <= `ST_RESET;
			st_link_reg <= `ST_RESET;
		end else begin
			st_meta_reg <= device_status_out;
			st_link_reg <= st_meta_reg;
		end
	end

	// Read target decode for the adjacent read datapath
	always_ff @(posedge spi_clk_in or posedge rst_in) begin
		if (rst_in) begin
			read_target_out <= spi_eeprom_pkg::RT_NONE;
			read_index_out <= 6'h00;
		end else if (!fresh_reg) begin
			read_target_out <= spi_eeprom_pkg::RT_NONE;
		end else if (bit_low_reg == 3'h7 && byte_cnt_reg == 3'h2) begin
			if (st_link_reg[`ST_WIP_BIT]) begin
				read_target_out <= spi_eeprom_pkg::RT_NONE;
			end else if (op_reg == `OP_ARRAY_READ) begin
				read_target_out <= spi_eeprom_pkg::RT_ARRAY;
				read_index_out <= in_byte[5:0];
			end else if (op_reg == `OP_SECURE_READ) begin
				if (addr_reg[9]) begin
					read_target_out <= spi_eeprom_pkg::RT_UID;
					read_index_out <= {2'h0, in_byte[3:0]};
				end else if (addr_reg[10]) begin
					read_target_out <= spi_eeprom_pkg::RT_LOCK_STATUS;
					read_index_out <= 6'h00;
				end else begin
					read_target_out <= spi_eeprom_pkg::RT_SECTOR;
					read_index_out <= in_byte[5:0];
				end
			end
		end
	end

	assign rd_active = fresh_reg && byte_cnt_reg != 3'h0 && op_reg == `OP_STATUS_READ;

	// Inverted bit count gives MSB first, wrapping every eight bits
	always_ff @(negedge spi_clk_in or posedge rst_in) begin
		if (rst_in) begin
			so_reg <= 1'b0;
		end else begin
			so_reg <= st_link_reg[~bit_low_reg];
		end
	end

	assign so_out = so_reg;
	assign so_oe_out = rd_active;

	////////////////////////////////////////////////////////////////////////////////
	// System domain: synchronisers

	logic cs_meta_reg;
	logic cs_sync_reg;
	logic cs_prev_reg;
	logic tog_meta_reg;
	logic tog_sync_reg;
	logic tog_prev_reg;
	logic wp_meta_reg;
	logic wp_sync_reg;
	logic pending_reg;
	logic frame_end;

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			cs_meta_reg <= 1'b1;
			cs_sync_reg <= 1'b1;
			cs_prev_reg <= 1'b1;
			tog_meta_reg <= 1'b0;
			tog_sync_reg <= 1'b0;
			tog_prev_reg <= 1'b0;
			wp_meta_reg <= 1'b1;
			wp_sync_reg <= 1'b1;
		end else begin
			cs_meta_reg <= cs_n_in;
			cs_sync_reg <= cs_meta_reg;
			cs_prev_reg <= cs_sync_reg;
			tog_meta_reg <= frame_tog_reg;
			tog_sync_reg <= tog_meta_reg;
			tog_prev_reg <= tog_sync_reg;
			wp_meta_reg <= wp_n_in;
			wp_sync_reg <= wp_meta_reg;
		end
	end

	assign frame_end = cs_sync_reg && !cs_prev_reg;

	// A select pulse with no clock edges is not an instruction
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			pending_reg <= 1'b0;
		end else if (tog_sync_reg != tog_prev_reg) begin
			pending_reg <= 1'b1;
		end else if (frame_end) begin
			pending_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Instruction decode at select rise

	logic wel_reg;
	logic bp_hi_reg;
	logic bp_lo_reg;
	logic lock_reg;
	logic ecc_reg;
	logic sec_locked_reg;
	spi_eeprom_pkg::engine_state_type eng_state_reg;
	logic [CNT_W-1:0] eng_cnt_reg;
	spi_eeprom_pkg::write_kind_type kind_reg;
	logic [7:0] new_status_reg;
	logic write_in_progress;
	logic whole;
	logic hw_locked;
	logic arr_protected;
	logic wel_set;
	logic wel_clear;
	spi_eeprom_pkg::write_kind_type start_kind;

	assign write_in_progress = eng_state_reg == spi_eeprom_pkg::ENG_BUSY;
	assign whole = bit_low_reg == 3'h0 && byte_cnt_reg != 3'h0;
	assign hw_locked = lock_reg && !wp_sync_reg;

	always_comb begin
		case ({bp_hi_reg, bp_lo_reg})
			`BP_QUARTER: arr_protected = addr_reg[14:13] == 2'h3;
			`BP_HALF: arr_protected = addr_reg[14];
			`BP_ALL: arr_protected = 1'b1;
			default: arr_protected = 1'b0;
		endcase
	end

	// Whole write-type frames clear the latch even when protection blocks the cycle
	always_comb begin
		wel_set = 1'b0;
		wel_clear = 1'b0;
		start_kind = spi_eeprom_pkg::WK_NONE;
		if (frame_end && pending_reg && !write_in_progress && byte_cnt_reg != 3'h0) begin
			case (op_reg)
				`OP_SET_WRITE_LATCH: wel_set = 1'b1;
				`OP_CLEAR_WRITE_LATCH: wel_clear = 1'b1;
				`OP_STATUS_WRITE: begin
					if (whole && byte_cnt_reg >= 3'h2 && wel_reg) begin
						wel_clear = 1'b1;
						if (!hw_locked) begin
							start_kind = spi_eeprom_pkg::WK_STATUS;
						end
					end
				end
				`OP_ARRAY_WRITE: begin
					if (whole && byte_cnt_reg >= 3'h4 && wel_reg) begin
						wel_clear = 1'b1;
						if (!arr_protected) begin
							start_kind = spi_eeprom_pkg::WK_ARRAY;
						end
					end
				end
				`OP_SECURE_WRITE: begin
					if (whole && byte_cnt_reg >= 3'h4 && wel_reg) begin
						wel_clear = 1'b1;
						if (addr_reg[10:9] == `SEC_SEL_DATA) begin
							if (!sec_locked_reg && {bp_hi_reg, bp_lo_reg} != `BP_ALL) begin
								start_kind = spi_eeprom_pkg::WK_SECTOR;
							end
						end else if (addr_reg[10:9] == `SEC_SEL_LOCK) begin
							if (byte_cnt_reg == 3'h4 && byte3_reg[`LOCK_DATA_BIT]) begin
								start_kind = spi_eeprom_pkg::WK_LOCK;
							end
						end
					end
				end
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Self-timed write engine

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			eng_state_reg <= spi_eeprom_pkg::ENG_IDLE;
			eng_cnt_reg <= '0;
			kind_reg <= spi_eeprom_pkg::WK_NONE;
			new_status_reg <= `ST_RESET;
		end else begin
			case (eng_state_reg)
				spi_eeprom_pkg::ENG_IDLE: begin
					if (start_kind != spi_eeprom_pkg::WK_NONE) begin
						eng_state_reg <= spi_eeprom_pkg::ENG_BUSY;
						eng_cnt_reg <= CNT_W'(WRITE_CYCLES - 1);
						kind_reg <= start_kind;
						new_status_reg <= byte1_reg;
					end
				end
				spi_eeprom_pkg::ENG_BUSY: begin
					if (eng_cnt_reg == '0) begin
						eng_state_reg <= spi_eeprom_pkg::ENG_IDLE;
					end else begin
						eng_cnt_reg <= eng_cnt_reg - CNT_W'(1);
					end
				end
				default: eng_state_reg <= spi_eeprom_pkg::ENG_IDLE;
			endcase
		end
	end

	// Non-volatile bits commit at cycle end; reset stands in for power-up
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			lock_reg <= 1'b0;
			bp_hi_reg <= 1'b0;
			bp_lo_reg <= 1'b0;
			sec_locked_reg <= 1'b0;
		end else if (write_in_progress && eng_cnt_reg == '0) begin
			if (kind_reg == spi_eeprom_pkg::WK_STATUS) begin
				lock_reg <= new_status_reg[`ST_LOCK_BIT];
				bp_hi_reg <= new_status_reg[`ST_BP_HI_BIT];
				bp_lo_reg <= new_status_reg[`ST_BP_LO_BIT];
			end
			if (kind_reg == spi_eeprom_pkg::WK_LOCK) begin
				sec_locked_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			wel_reg <= 1'b0;
		end else if (wel_set) begin
			wel_reg <= 1'b1;
		end else if (wel_clear || (write_in_progress && eng_cnt_reg == '0)) begin
			wel_reg <= 1'b0;
		end
	end

	// A clean read is the only clear, so no set/clear race exists
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			ecc_reg <= 1'b0;
		end else if (ecc_read_done_in) begin
			ecc_reg <= ecc_corrected_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			write_start_out <= 1'b0;
			write_kind_out <= spi_eeprom_pkg::WK_NONE;
			write_addr_out <= 16'h0000;
			write_data_out <= 8'h00;
		end else begin
			write_start_out <= start_kind != spi_eeprom_pkg::WK_NONE;
			if (start_kind != spi_eeprom_pkg::WK_NONE) begin
				write_kind_out <= start_kind;
				write_addr_out <= addr_reg;
				write_data_out <= (start_kind == spi_eeprom_pkg::WK_STATUS) ? byte1_reg : byte3_reg;
			end
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			device_status_out <= `ST_RESET;
		end else begin
			device_status_out <= {lock_reg, 2'h0, ecc_reg, bp_hi_reg, bp_lo_reg, wel_reg, write_in_progress};
		end
	end

	assign sector_locked_out = sec_locked_reg;

endmodule : spi_eeprom_status_cmd

// file: test/spi_master_model.sv
`timescale 1ns/1ps
module spi_master_model (
	output logic spi_clk_out,
	output logic cs_n_out,
	output logic mosi_out,
	input wire logic so_in,
	output logic rd_done_out,
	output logic [15:0] rd_data_out
);
	logic [31:0] rx;
	bit mode3 = 1'h0;
	initial begin
		spi_clk_out = 1'h0;
		cs_n_out = 1'h1;
		mosi_out = 1'h0;
		rd_done_out = 1'h0;
		rd_data_out = 16'h0000;
	end
	////////////////////////////////
	// Clock stands still between frames; bits are left aligned
	task automatic frame(input logic [31:0] bits, input int n);
		// Idle level settles before select falls, so a mode switch adds no edge to the frame
		spi_clk_out = mode3;
		#16;
		cs_n_out = 1'h0;
		#16;
		for (int i = 0; i < n; i++) begin
			spi_clk_out = 1'h0;
			mosi_out = bits[31-i];
			#16;
			rx = {rx[30:0], so_in};
			spi_clk_out = 1'h1;
			#16;
		end
		spi_clk_out = mode3;
		#16;
		cs_n_out = 1'h1;
		mosi_out = ~mosi_out;
		if (bits[31:24] == 8'h05) begin
			rd_data_out = rx[15:0];
			rd_done_out = 1'h1;
			#1;
			rd_done_out = 1'h0;
		end
		#48;
	endtask : frame
endmodule : spi_master_model

// file: test/spi_eeprom_status_props.sv
`timescale 1ns/1ps
module spi_eeprom_status_props #(
	parameter int WRITE_CYCLES = 20
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic cs_n_in,
	input wire logic ecc_read_done_in,
	input wire logic ecc_corrected_in,
	input wire logic so_oe_out,
	input wire logic write_start_out,
	input wire spi_eeprom_pkg::write_kind_type write_kind_out,
	input wire logic [7:0] device_status_out,
	input wire logic sector_locked_out
);
	int busy_cnt;
	logic write_in_progress;
	assign write_in_progress = device_status_out[0];
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			busy_cnt <= 0;
		end else begin
			busy_cnt <= write_in_progress ? busy_cnt + 1 : 0;
		end
	end
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	////////////////////////////////
	a_start_sets_wip: assert property (write_start_out |-> ##[1:3] write_in_progress)
		else $error("write start without busy flag");
	// Slack of two covers the registered status path
	a_wip_length: assert property ($fell(write_in_progress) |-> busy_cnt >= WRITE_CYCLES - 2 && busy_cnt <= WRITE_CYCLES + 2)
		else $error("busy flag length wrong");
	a_busy_no_start: assert property (write_start_out |-> !$past(write_in_progress))
		else $error("write started while busy");
	a_wel_idle_only: assert property ($rose(device_status_out[1]) |-> !write_in_progress)
		else $error("latch set while busy");
	a_start_clears_wel: assert property (write_start_out |-> ##[1:3] !device_status_out[1])
		else $error("latch not cleared by write");
	a_unused_zero: assert property (device_status_out[6:5] == 2'h0)
		else $error("unused status bits set");
	a_nv_commit: assert property ($changed({device_status_out[7], device_status_out[3:2]}) |-> $past(write_in_progress))
		else $error("protect bits changed outside a cycle");
	a_ecc_update: assert property (ecc_read_done_in |-> ##2 device_status_out[4] == $past(ecc_corrected_in, 2))
		else $error("ecc flag does not follow read");
	a_ecc_holds: assert property ($changed(device_status_out[4]) |-> $past(ecc_read_done_in, 2))
		else $error("ecc flag changed without read");
	a_oe_deselect: assert property (cs_n_in |-> !so_oe_out)
		else $error("output driven while deselected");
	a_lock_by_cmd: assert property ($rose(sector_locked_out) |-> write_kind_out == spi_eeprom_pkg::WK_LOCK)
		else $error("sector locked by other write");
	c_status_wr: cover property (write_start_out && write_kind_out == spi_eeprom_pkg::WK_STATUS);
	c_locked: cover property ($rose(sector_locked_out));
	c_ecc: cover property ($rose(device_status_out[4]));
	c_oe: cover property ($rose(so_oe_out));
endmodule : spi_eeprom_status_props
bind spi_eeprom_status_cmd spi_eeprom_status_props #(.WRITE_CYCLES(WRITE_CYCLES)) i_spi_eeprom_status_props (
	.clk_sys_in(clk_sys_in), .rst_in(rst_in), .cs_n_in(cs_n_in), .ecc_read_done_in(ecc_read_done_in),
	.ecc_corrected_in(ecc_corrected_in), .so_oe_out(so_oe_out), .write_start_out(write_start_out),
	.write_kind_out(write_kind_out), .device_status_out(device_status_out), .sector_locked_out(sector_locked_out));

// file: test/tb.sv
`timescale 1ns/1ps
module tb;
	localparam int WC = 400;
	logic clk_sys_in = 1'h0;
	logic rst_in = 1'h1;
	logic wp_n_in = 1'h1;
	logic ecc_read_done_in = 1'h0;
	logic ecc_corrected_in = 1'h0;
	logic spi_clk, cs_n, mosi, so_out, so_oe_out, write_start_out, sector_locked_out, rd_done, prot;
	logic [15:0] write_addr_out, rd_data, a;
	logic [7:0] write_data_out, device_status_out, d, bp;
	logic [5:0] read_index_out;
	logic [26:0] e;
	spi_eeprom_pkg::write_kind_type write_kind_out;
	spi_eeprom_pkg::read_target_type read_target_out;
	wire so_line = so_oe_out ? so_out : 1'hZ;
	int err_total = 0;
	int total_checks = 0;
	int seed = 32'h107FCD1D;
	logic [15:0] rd_q[$];
	logic [26:0] wr_q[$];
	logic [15:0] addrs[4] = '{16'h3FFF, 16'h4000, 16'h5FFF, 16'h6000};
	logic [23:0] sec[4] = '{24'h830025, 24'h830400, 24'h83020B, 24'h031234};
	spi_eeprom_pkg::read_target_type tgt[4] = '{spi_eeprom_pkg::RT_SECTOR, spi_eeprom_pkg::RT_LOCK_STATUS,
		spi_eeprom_pkg::RT_UID, spi_eeprom_pkg::RT_ARRAY};
	logic [5:0] idx[4] = '{6'h25, 6'h00, 6'h0B, 6'h34};
	always #2.5 clk_sys_in = ~clk_sys_in;
	spi_eeprom_status_cmd #(.WRITE_CYCLES(WC)) i_spi_eeprom_status_cmd (
		.clk_sys_in(clk_sys_in), .rst_in(rst_in), .spi_clk_in(spi_clk), .cs_n_in(cs_n), .serial_in(mosi),
		.wp_n_in(wp_n_in), .ecc_read_done_in(ecc_read_done_in), .ecc_corrected_in(ecc_corrected_in),
		.so_out(so_out), .so_oe_out(so_oe_out), .write_start_out(write_start_out), .write_kind_out(write_kind_out),
		.write_addr_out(write_addr_out), .write_data_out(write_data_out), .read_target_out(read_target_out),
		.read_index_out(read_index_out), .device_status_out(device_status_out), .sector_locked_out(sector_locked_out));
	spi_master_model i_spi_master_model (.spi_clk_out(spi_clk), .cs_n_out(cs_n), .mosi_out(mosi), .so_in(so_line),
		.rd_done_out(rd_done), .rd_data_out(rd_data));
	////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : close_out
	task automatic send(input logic [31:0] b, input int n);
		i_spi_master_model.frame(b, n);
	endtask : send
	task automatic idle;
		for (int i = 0; i < WC + 50 && device_status_out[0] !== 1'h0; i++) @(posedge clk_sys_in);
	endtask : idle
	task automatic status_read_cmd(input logic [7:0] s);
		rd_q.push_back({s, s});
		send(32'h05000000, 24);
	endtask : status_read_cmd
	// Refused writes push nothing, so a stray start pops the sentinel
	task automatic status_write_cmd(input logic [7:0] s, input bit ok);
		if (ok) wr_q.push_back({spi_eeprom_pkg::WK_STATUS, 16'h0000, s});
		send(32'h06000000, 8);
		send({8'h01, s, 16'h0000}, 16);
	endtask : status_write_cmd
	task automatic wr(input logic [31:0] b, input spi_eeprom_pkg::write_kind_type k, input bit ok);
		if (ok) wr_q.push_back({k, b[23:0]});
		send(32'h06000000, 8);
		send(b, 32);
		idle();
	endtask : wr
	task automatic ecc(input logic c);
		@(posedge clk_sys_in);
		ecc_read_done_in <= 1'h1;
		ecc_corrected_in <= c;
		@(posedge clk_sys_in);
		ecc_read_done_in <= 1'h0;
		ecc_corrected_in <= ~c;
		repeat (4) @(posedge clk_sys_in);
	endtask : ecc
	////////////////////////////////
	always @(posedge rd_done) check("status read", rd_data, rd_q.size() ? rd_q.pop_front() : 16'hDEAD);
	// Sampled mid-cycle, away from the edge that launches the pulse
	always @(negedge clk_sys_in) begin
		if (write_start_out === 1'h1) begin
			e = wr_q.size() ? wr_q.pop_front() : 27'h7FFFFFF;
			check("write start", {write_kind_out, (write_kind_out == spi_eeprom_pkg::WK_ARRAY ? write_addr_out : e[23:8]),
				write_data_out}, e);
		end
	end
	initial begin
		repeat (12) @(posedge clk_sys_in);
		rst_in <= 1'h0;
		repeat (4) @(posedge clk_sys_in);
		check("status reset", device_status_out, 8'h00);
		status_read_cmd(8'h00);
		$display("test reset done");
		for (int m = 0; m < 2; m++) begin
			i_spi_master_model.mode3 = m[0];
			send(32'h06000000, 8);
			status_read_cmd(8'h02);
			send(32'h04000000, 8);
			status_read_cmd(8'h00);
		end
		$display("test latch done");
		status_write_cmd(8'hFF, 1'h1);
		status_read_cmd(8'h01);
		send(32'h06000000, 8);
		idle();
		status_read_cmd(8'h8C);
		$display("test status write done");
		@(posedge clk_sys_in) wp_n_in <= 1'h0;
		status_write_cmd(8'h00, 1'h0);
		idle();
		status_read_cmd(8'h8C);
		@(posedge clk_sys_in) wp_n_in <= 1'h1;
		status_write_cmd(8'h00, 1'h1);
		idle();
		status_read_cmd(8'h00);
		$display("test hardware lock done");
		for (int b = 3; b >= 0; b--) begin
			bp = 8'(b << 2);
			status_write_cmd(bp, 1'h1);
			idle();
			for (int k = 0; k < 4; k++) begin
				a = addrs[k];
				d = 8'($random(seed));
				prot = b == 3 || (b == 2 && a >= 16'h4000) || (b == 1 && a >= 16'h6000);
				wr({8'h02, a, d}, spi_eeprom_pkg::WK_ARRAY, !prot);
				status_read_cmd(bp);
			end
		end
		$display("test protect done");
		send(32'h06000000, 8);
		send(32'h020100A5, 31);
		repeat (20) @(posedge clk_sys_in);
		status_read_cmd(8'h02);
		send(32'h04000000, 8);
		$display("test partial frame done");
		ecc(1'h1);
		status_read_cmd(8'h10);
		status_read_cmd(8'h10);
		ecc(1'h0);
		status_read_cmd(8'h00);
		$display("test ecc done");
		for (int k = 0; k < 4; k++) begin
			send({sec[k], 8'h00}, 24);
			check("read target", read_target_out, tgt[k]);
			if (k != 1) check("read index", read_index_out, idx[k]);
		end
		wr(32'h8200055A, spi_eeprom_pkg::WK_SECTOR, 1'h1);
		wr(32'h82040002, spi_eeprom_pkg::WK_LOCK, 1'h1);
		check("sector lock", sector_locked_out, 1'h1);
		wr(32'h8200055A, spi_eeprom_pkg::WK_SECTOR, 1'h0);
		status_read_cmd(8'h00);
		$display("test security done");
		check("pending", rd_q.size() + wr_q.size(), 0);
		close_out();
	end
	initial begin
		#400000;
		err_total++;
		close_out();
	end
endmodule : tb
